// file: hw/cri_idle_detect.sv
// bus idle detector: counts whole recessive bits at the programmed bit timing
// assumes rx is already synchronous to pclk; run low holds it cleared
`timescale 1ns/10ps
`include "cri_params.svh"

module cri_idle_detect (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    run,
  input  wire cri_pkg::cri_bit_config_type timing,
  input  wire logic                    rx,
  output logic                         idle_found
);
  import cri_pkg::*;

  logic [7:0] clk_count;
  logic [4:0] tq_count;
  logic [3:0] bit_count;
  logic       saw_dominant;

  wire  [7:0] tq_clocks  = 8'(`CRI_TQ_CLOCKS_PER * (int'(timing.quantum_prescaler) + 1));
  wire  [4:0] bit_quanta = `CRI_BIT_FIXED_TQ + 5'(timing.time_segment_one) + 5'(timing.time_segment_two);
  wire        tq_end     = clk_count == tq_clocks - 8'h01;
  wire        bit_end    = tq_end && tq_count == bit_quanta - 5'h01;
  wire        bit_clean  = !saw_dominant && rx;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_count    <= 8'h00;
      tq_count     <= 5'h00;
      bit_count    <= 4'h0;
      saw_dominant <= 1'b0;
      idle_found   <= 1'b0;
    end else if (!run) begin
      clk_count    <= 8'h00;
      tq_count     <= 5'h00;
      bit_count    <= 4'h0;
      saw_dominant <= 1'b0;
      idle_found   <= 1'b0;
    end else begin
      clk_count    <= tq_end ? 8'h00 : clk_count + 8'h01;
      tq_count     <= bit_end ? 5'h00 : (tq_end ? tq_count + 5'h01 : tq_count);
      saw_dominant <= bit_end ? 1'b0 : (saw_dominant || !rx);
      if (bit_end) begin
        // any dominant sample restarts the run of recessive bits
        bit_count <= bit_clean ? bit_count + 4'h1 : 4'h0;
      end
      if (bit_count == `CRI_IDLE_BITS) begin
        idle_found <= 1'b1;
      end
    end
  end

endmodule

// file: hw/cri_params.svh
// constants for the reset, init and payload block of the can controller
// assumes a 12-bit apb byte address and 32-bit data words
`ifndef CRI_PARAMS_SVH
`define CRI_PARAMS_SVH

`define CRI_OFS_MASTER       12'h000
`define CRI_OFS_STATUS       12'h004
`define CRI_OFS_BIT_CONFIG   12'h008
`define CRI_OFS_ERR_COUNT    12'h00c
`define CRI_OFS_RESET_FLAG   12'h010
`define CRI_OFS_PAYLOAD      12'h100
`define CRI_PAYLOAD_SPAN     12'h200

`define CRI_BIT_RESET_REQ    0
`define CRI_BIT_BUS_READY    0
`define CRI_BIT_RESET_STATE  3
`define CRI_BIT_FLAG         0

`define CRI_RST_BIT_CONFIG   16'h0000
`define CRI_RST_COUNT        8'h00
`define CRI_IDLE_BITS        4'hb
`define CRI_BIT_FIXED_TQ     5'h03
`define CRI_TQ_CLOCKS_PER    2
`define CRI_DLC_FULL_LEN     4'h8

`endif

// file: hw/cri_payload_ram.sv
// payload byte store: one set of data bytes per mailbox
// assumes callers never write both ports to one byte in one cycle; bus port wins
`timescale 1ns/10ps
`include "cri_params.svh"

module cri_payload_ram #(
  parameter int MAILBOXES = 16,
  parameter int BYTES     = 8
) (
  input  wire logic                   pclk,
  input  wire cri_pkg::cri_byte_write_type bus_wr,
  input  wire cri_pkg::cri_byte_write_type link_wr,
  input  wire logic [3:0]             bus_rd_mbox,
  input  wire logic [2:0]             bus_rd_index,
  output logic [7:0]                  bus_rd_data,
  input  wire logic [3:0]             link_rd_mbox,
  input  wire logic [2:0]             link_rd_index,
  output logic [7:0]                  link_rd_data
);
  import cri_pkg::*;

  // no reset on purpose: contents survive every reset
  logic [7:0] mem [MAILBOXES][BYTES];

  // one process owns the array; the bus port wins a clash on one byte
  wire same_cell = bus_wr.mbox == link_wr.mbox && bus_wr.index == link_wr.index;
  wire link_ok   = link_wr.valid && !(bus_wr.valid && same_cell);

  always_ff @(posedge pclk) begin
    if (bus_wr.valid) begin
      mem[bus_wr.mbox][bus_wr.index] <= bus_wr.data;
    end
    if (link_ok) begin
      mem[link_wr.mbox][link_wr.index] <= link_wr.data;
    end
  end

  assign bus_rd_data  = mem[bus_rd_mbox][bus_rd_index];
  assign link_rd_data = mem[link_rd_mbox][link_rd_index];

endmodule

// file: hw/cri_pkg.sv
// types shared by the reset, init and payload block
// assumes cri_params.svh supplies the numeric constants
package cri_pkg;

  typedef enum logic [1:0] {
    CRI_NORMAL        = 2'b00,
    CRI_RESET_PENDING = 2'b01,
    CRI_CONFIG        = 2'b10,
    CRI_POWER_UP      = 2'b11
  } cri_mode_type;

  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic       sample_point_count;
    logic [2:0] time_segment_two;
    logic [3:0] time_segment_one;
    logic [5:0] quantum_prescaler;
  } cri_bit_config_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] mbox;
    logic [2:0] index;
    logic [7:0] data;
  } cri_byte_write_type;

endpackage

// file: hw/cri_top.sv
// reset, configuration mode, bus idle start-up and payload store of a can controller
// assumes an apb master on pclk and a protocol engine that reports frame activity
// Function
// - sixteen payload sets, eight read/write bytes each
// - hardware reset sets reset request and reset state, then initialises
// - hardware reset restores registers but keeps payload contents
// - software reset waits for a frame in progress to finish
// - reset state stays one throughout software initialisation
// - software reset clears both error counters only
// - configuration mode means reset request and reset state both one
// - clearing reset request clears reset state and starts power-up
// - power-up ends after eleven recessive bits; only then bus traffic
// - reset flag sets after power-on and after standby wake
// - bit configuration writable always; change it only in configuration mode
// - one quantum lasts two times prescaler plus one clocks
// - bit length is three plus both segment values in quanta
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "cri_params.svh"

module cri_top #(
  parameter int MAILBOXES = 16,
  parameter int BYTES     = 8
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       standby_wake,
  input  wire logic                       frame_active,
  input  wire logic                       bus_rx,
  input  wire logic                       tx_error_step,
  input  wire logic                       rx_error_step,
  input  wire cri_pkg::cri_byte_write_type rx_byte,
  input  wire logic [3:0]                 tx_mbox,
  input  wire logic [2:0]                 tx_index,
  input  wire logic [3:0]                 tx_length_code,
  output logic [7:0]                      tx_byte,
  output logic                            tx_byte_used,
  output logic                            bus_enable,
  output logic                            config_mode,
  output logic                            reset_interrupt_flag,
  output cri_pkg::cri_bit_config_type     bit_config_register
);
  import cri_pkg::*;

  generate
    if (MAILBOXES < 1 || MAILBOXES > 16 || BYTES != 8) begin : g_bad_size
      $error("cri_top: mailbox count 1..16 and eight bytes per set only");
    end
  endgenerate

  // the bit configuration is read back whole in one data word
  localparam int CFG_W = $bits(cri_bit_config_type);

  generate
    if (CFG_W > 32) begin : g_bad_cfg
      $error("cri_top: bit configuration wider than a data word");
    end
  endgenerate

  cri_mode_type mode;
  cri_mode_type next_mode;
  logic         reset_request_bit;
  logic         reset_state_bit;
  logic [7:0]   transmit_error_counter;
  logic [7:0]   receive_error_counter;
  logic         idle_found;

  // register map, byte addresses, one register per word:
  //   000 master control, bit 0 reset request
  //   004 general status, bit 3 reset state, bit 0 bus ready; read only
  //   008 bit configuration, fields packed from bit 0 upward
  //   00c error counters, transmit in 7:0, receive in 15:8; read only
  //   010 reset flag, bit 0, write one to clear
  //   100 payload, mailbox * 20 + byte * 4, byte in 7:0
  // apb decode
  wire        setup      = psel && !penable;
  wire        wr_access  = psel && penable && pready && pwrite;
  wire [11:0] pay_offset = paddr - `CRI_OFS_PAYLOAD;
  // words past the last mailbox answer with an error
  wire        in_payload = paddr >= `CRI_OFS_PAYLOAD && pay_offset < `CRI_PAYLOAD_SPAN
                           && int'(pay_offset[8:5]) < MAILBOXES;
  wire        hit_master = paddr == `CRI_OFS_MASTER;
  wire        hit_status = paddr == `CRI_OFS_STATUS;
  wire        hit_bitcfg = paddr == `CRI_OFS_BIT_CONFIG;
  wire        hit_errcnt = paddr == `CRI_OFS_ERR_COUNT;
  wire        hit_flag   = paddr == `CRI_OFS_RESET_FLAG;
  wire        mapped     = hit_master || hit_status || hit_bitcfg || hit_errcnt || hit_flag || in_payload;
  wire        misaligned = paddr[1:0] != 2'b00;

  // payload store
  cri_byte_write_type bus_wr;
  logic [7:0]         bus_rd_data;
  logic [7:0]         link_rd_data;

  assign bus_wr.valid = wr_access && in_payload && !misaligned;
  assign bus_wr.mbox  = pay_offset[8:5];
  assign bus_wr.index = pay_offset[4:2];
  assign bus_wr.data  = pwdata[7:0];

  cri_payload_ram #(
    .MAILBOXES (MAILBOXES),
    .BYTES     (BYTES)
  ) u_ram (
    .pclk          (pclk),
    .bus_wr        (bus_wr),
    .link_wr       (rx_byte),
    .bus_rd_mbox   (pay_offset[8:5]),
    .bus_rd_index  (pay_offset[4:2]),
    .bus_rd_data   (bus_rd_data),
    .link_rd_mbox  (tx_mbox),
    .link_rd_index (tx_index),
    .link_rd_data  (link_rd_data)
  );

  // start-up counts at the live bit timing; rewriting it mid start-up skews the count
  cri_idle_detect u_idle (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (mode == CRI_POWER_UP),
    .timing     (bit_config_register),
    .rx         (bus_rx),
    .idle_found (idle_found)
  );

  // control register writes
  wire wr_master    = wr_access && hit_master;
  wire wr_bitcfg    = wr_access && hit_bitcfg;
  wire clear_flag   = wr_access && hit_flag && pwdata[`CRI_BIT_FLAG];
  // a wake sets the request like a hardware reset; bit configuration is kept
  wire next_request = standby_wake ? 1'b1 : (wr_master ? pwdata[`CRI_BIT_RESET_REQ] : reset_request_bit);
  wire next_flag    = standby_wake || (reset_interrupt_flag && !clear_flag);
  wire [CFG_W-1:0] new_config = pwdata[CFG_W-1:0];

  // mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      CRI_NORMAL: begin
        if (reset_request_bit) begin
          next_mode = frame_active ? CRI_RESET_PENDING : CRI_CONFIG;
        end
      end
      CRI_RESET_PENDING: begin
        // reset state stays low while the frame drains
        if (!frame_active) begin
          next_mode = CRI_CONFIG;
        end
      end
      CRI_CONFIG: begin
        if (!reset_request_bit) begin
          next_mode = CRI_POWER_UP;
        end
      end
      CRI_POWER_UP: begin
        // a new request during start-up drops straight back to configuration
        if (reset_request_bit) begin
          next_mode = CRI_CONFIG;
        end else if (idle_found) begin
          next_mode = CRI_NORMAL;
        end
      end
    endcase
    if (standby_wake) begin
      next_mode = CRI_CONFIG;
    end
  end

  wire entering_config = next_mode == CRI_CONFIG && mode != CRI_CONFIG;

  // registered copies of the mode decode keep every output a flop
  wire       next_state      = next_mode == CRI_CONFIG;
  wire       next_config     = next_request && next_state;
  wire       next_bus_enable = next_mode == CRI_NORMAL;
  wire       bus_ready       = mode == CRI_NORMAL;
  // counters wrap; limiting them belongs to the error state logic
  wire [7:0] next_tx_count   = transmit_error_counter + 8'(tx_error_step);
  wire [7:0] next_rx_count   = receive_error_counter + 8'(rx_error_step);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode              <= CRI_CONFIG;
      reset_request_bit <= 1'b1;
      reset_state_bit   <= 1'b1;
    end else begin
      mode              <= next_mode;
      reset_request_bit <= next_request;
      reset_state_bit   <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_error_counter <= `CRI_RST_COUNT;
      receive_error_counter  <= `CRI_RST_COUNT;
    end else if (entering_config) begin
      // software reset touches only the counters
      transmit_error_counter <= `CRI_RST_COUNT;
      receive_error_counter  <= `CRI_RST_COUNT;
    end else begin
      transmit_error_counter <= next_tx_count;
      receive_error_counter  <= next_rx_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_config_register <= `CRI_RST_BIT_CONFIG;
    end else if (wr_bitcfg) begin
      // accepted in every mode; software keeps changes to configuration mode
      bit_config_register <= new_config;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_interrupt_flag <= 1'b1;
    end else begin
      // a wake in the clearing cycle keeps the flag set
      reset_interrupt_flag <= next_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_mode <= 1'b1;
      bus_enable  <= 1'b0;
    end else begin
      config_mode <= next_config;
      bus_enable  <= next_bus_enable;
    end
  end

  // transmit side byte fetch, byte one at index zero
  // any code with the top bit set still means eight bytes
  wire [3:0] used_len  = tx_length_code[3] ? `CRI_DLC_FULL_LEN : {1'b0, tx_length_code[2:0]};
  wire       next_used = {1'b0, tx_index} < used_len;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte      <= 8'h00;
      tx_byte_used <= 1'b0;
    end else begin
      tx_byte      <= link_rd_data;
      tx_byte_used <= next_used;
    end
  end

  // apb read data, captured in setup so the access phase needs no wait
  // an event in the access cycle shows on the next read, not this one
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h00000000;
    if (hit_master) begin
      rd_word[`CRI_BIT_RESET_REQ] = reset_request_bit;
    end
    if (hit_status) begin
      rd_word[`CRI_BIT_RESET_STATE] = reset_state_bit;
      rd_word[`CRI_BIT_BUS_READY]   = bus_ready;
    end
    if (hit_bitcfg) begin
      rd_word[CFG_W-1:0] = bit_config_register;
    end
    if (hit_errcnt) begin
      rd_word[15:0] = {receive_error_counter, transmit_error_counter};
    end
    if (hit_flag) begin
      rd_word[`CRI_BIT_FLAG] = reset_interrupt_flag;
    end
    if (in_payload) begin
      rd_word[7:0] = bus_rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && (!mapped || misaligned);
      if (setup && !pwrite && mapped && !misaligned) begin
        prdata <= rd_word;
      end else if (setup) begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

// file: sim/cri_bus_model.sv
// far side stand-in: protocol engine and bus line seen by the block
// assumes one pclk domain; go starts a frame only while idle
`timescale 1ns/10ps

module cri_bus_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [3:0] mbox,
  input  wire logic [3:0] len,
  input  wire logic       glitch,
  output logic            frame_active,
  output logic            bus_rx,
  output logic [3:0]      tx_mbox,
  output logic [2:0]      tx_index,
  output logic [3:0]      tx_length_code,
  output logic            tx_error_step,
  output logic            rx_error_step
);
  logic [5:0] cnt;
  assign frame_active = cnt != 6'h00;
  assign tx_index = cnt[4:2];
  // idle line is recessive; glitch forces one dominant sample
  assign bus_rx = frame_active ? cnt[0] : !glitch;
  assign tx_error_step = cnt == 6'h1f;
  assign rx_error_step = cnt == 6'h17;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 6'h00;
      tx_mbox <= 4'h0;
      tx_length_code <= 4'h0;
    end else if (go && cnt == 6'h00) begin
      cnt <= 6'h20;
      tx_mbox <= mbox;
      tx_length_code <= len;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
    end
  end
endmodule

// file: sim/cri_top_chk.sv
// port checks for the reset, init and payload block
// assumes one pclk domain; bound to every cri_top below
`timescale 1ns/10ps
`include "cri_params.svh"

module cri_top_chk #(
  parameter int MAILBOXES = 16,
  parameter int BYTES     = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        standby_wake,
  input wire logic        frame_active,
  input wire logic [2:0]  tx_index,
  input wire logic [3:0]  tx_length_code,
  input wire logic        tx_byte_used,
  input wire logic        bus_enable,
  input wire logic        config_mode,
  input wire logic        reset_interrupt_flag,
  input wire cri_pkg::cri_bit_config_type bit_config_register
);
  import cri_pkg::*;
  localparam int BW = $bits(cri_bit_config_type);
  wire [3:0] full_len = tx_length_code[3] ? 4'h8 : tx_length_code;
  wire       used_now = {1'b0, tx_index} < full_len;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bcr_wr_s;
    psel && penable && pready && pwrite && paddr == `CRI_OFS_BIT_CONFIG;
  endsequence

  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_wake_forces_config: assert property (standby_wake |=> config_mode && reset_interrupt_flag)
    else $error("wake did not force config and flag");
  a_no_config_midframe: assert property ($rose(config_mode) && !$past(standby_wake) |-> !$past(frame_active))
    else $error("config entered mid frame");
  a_config_blocks_bus: assert property (config_mode |-> !bus_enable)
    else $error("bus enabled in config mode");
  a_powerup_waits: assert property ($fell(config_mode) |-> !bus_enable [*8])
    else $error("bus enabled before idle run");
  a_bcr_write_lands: assert property (bcr_wr_s |=> bit_config_register == $past(pwdata[BW-1:0]))
    else $error("bit config write lost");
  a_used_by_length: assert property (1'b1 |=> tx_byte_used == $past(used_now))
    else $error("byte used flag wrong");
endmodule

bind cri_top cri_top_chk #(.MAILBOXES(MAILBOXES), .BYTES(BYTES)) cri_top_chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .standby_wake, .frame_active, .tx_index, .tx_length_code, .tx_byte_used,
  .bus_enable, .config_mode, .reset_interrupt_flag, .bit_config_register);

// file: sim/tb_top.sv
// self-checking bench: apb master, bus model, result queue and monitor
// assumes cri_top with one access cycle per transfer
`timescale 1ns/10ps
`include "cri_params.svh"

module tb_top;
  import cri_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby_wake, frame_active, bus_rx;
  logic tx_error_step, rx_error_step, tx_byte_used, bus_enable, config_mode, reset_interrupt_flag;
  logic go, glitch, pa;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, n;
  logic [3:0] tx_mbox, tx_length_code, g_mbox, g_len, pm, pl;
  logic [2:0] tx_index, pi;
  logic [7:0] tx_byte;
  logic [7:0] exp_mem [16][8];
  logic [32:0] notes [$];
  cri_byte_write_type rx_byte;
  cri_bit_config_type bit_config_register, cfg;
  integer bad_count, samples_checked, seed, i, k;

  cri_top cri_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .standby_wake, .frame_active, .bus_rx, .tx_error_step, .rx_error_step, .rx_byte, .tx_mbox,
    .tx_index, .tx_length_code, .tx_byte, .tx_byte_used, .bus_enable, .config_mode,
    .reset_interrupt_flag, .bit_config_register);
  cri_bus_model cri_bus_model_inst (.pclk, .presetn, .go, .mbox(g_mbox), .len(g_len), .glitch,
    .frame_active, .bus_rx, .tx_mbox, .tx_index, .tx_length_code, .tx_error_step, .rx_error_step);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task check(input logic [63:0] seen, input logic [63:0] want);
    samples_checked = samples_checked + 1;
    if (seen !== want) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task timeout;
    bad_count = bad_count + 1;
    complete_run;
  endtask

  // each transfer notes its expected {pslverr, prdata}; writes read back zero
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    notes.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k = k + 1;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) timeout;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  function automatic logic [11:0] pa_f(input integer j);
    return `CRI_OFS_PAYLOAD + 12'(j / 8) * 12'h020 + 12'(j % 8) * 12'h004;
  endfunction

  task read_all;
    for (i = 0; i < 128; i++) rd(pa_f(i), {24'h0, exp_mem[i/8][i%8]});
  endtask

  task until_idle;
    k = 0;
    do begin
      @(posedge pclk);
      k = k + 1;
    end while (frame_active === 1'b1 && k < 100);
    if (k >= 100) timeout;
  endtask

  task frame(input logic [3:0] m, input logic [3:0] l);
    @(posedge pclk);
    g_mbox <= m;
    g_len <= l;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (presetn === 1'b1 && pready === 1'b1) check({pslverr, prdata}, notes.pop_front());
    if (pa === 1'b1) check({tx_byte_used, tx_byte}, {{1'b0, pi} < (pl[3] ? 4'h8 : pl), exp_mem[pm][pi]});
    pa <= frame_active;
    pm <= tx_mbox;
    pi <= tx_index;
    pl <= tx_length_code;
  end

  initial begin
    {presetn, psel, penable, pwrite, standby_wake, go, glitch} = 7'h00;
    {paddr, pwdata, g_mbox, g_len, rx_byte} = '0;
    seed = 59;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CRI_OFS_MASTER, 32'h1);
    rd(`CRI_OFS_STATUS, 32'h8);
    rd(`CRI_OFS_BIT_CONFIG, 32'h0);
    rd(`CRI_OFS_RESET_FLAG, 32'h1);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h102, 32'hff, {1'b1, 32'h0});
    apb(1'b1, `CRI_OFS_RESET_FLAG, 32'h1, 33'h0);
    rd(`CRI_OFS_RESET_FLAG, 32'h0);
    cfg = '{resync_jump_width: 2'h1, sample_point_count: 1'b0, time_segment_two: 3'h3,
            time_segment_one: 4'h4, quantum_prescaler: 6'h00};
    apb(1'b1, `CRI_OFS_BIT_CONFIG, 32'(cfg), 33'h0);
    for (i = 0; i < 128; i++) begin
      n = $random(seed);
      exp_mem[i/8][i%8] = n[7:0];
      apb(1'b1, pa_f(i), n, 33'h0);
    end
    read_all;
    @(posedge pclk);
    rx_byte <= '{1'b1, 4'h5, 3'h2, 8'ha5};
    exp_mem[5][2] = 8'ha5;
    @(posedge pclk);
    rx_byte <= '0;
    rd(pa_f(42), 32'ha5);
    apb(1'b1, `CRI_OFS_MASTER, 32'h0, 33'h0);
    rd(`CRI_OFS_STATUS, 32'h0);
    repeat (50) @(posedge pclk);
    glitch <= 1'b1;
    @(posedge pclk);
    glitch <= 1'b0;
    // eleven bits of 10 quanta, 2 clocks each, after the broken bit
    for (n = 0; bus_enable !== 1'b1 && n < 400; n++) @(posedge pclk);
    check(n >= 219 && n <= 245, 1'b1);
    rd(`CRI_OFS_STATUS, 32'h1);
    frame(4'h3, 4'h5);
    until_idle;
    frame(4'h5, 4'hc);
    until_idle;
    rd(`CRI_OFS_ERR_COUNT, 32'h0202);
    frame(4'h0, 4'h1);
    apb(1'b1, `CRI_OFS_MASTER, 32'h1, 33'h0);
    rd(`CRI_OFS_STATUS, 32'h0);
    check(config_mode, 1'b0);
    until_idle;
    repeat (3) @(posedge pclk);
    rd(`CRI_OFS_STATUS, 32'h8);
    rd(`CRI_OFS_ERR_COUNT, 32'h0);
    rd(`CRI_OFS_BIT_CONFIG, 32'(cfg));
    @(posedge pclk);
    standby_wake <= 1'b1;
    @(posedge pclk);
    standby_wake <= 1'b0;
    rd(`CRI_OFS_RESET_FLAG, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CRI_OFS_BIT_CONFIG, 32'h0);
    read_all;
    complete_run;
  end
endmodule
